// [core/i2c_coll_defs.svh]
// Register offsets, field positions and reset values of the collision-aware master port.
// Assumes a 32-bit APB slave with byte addresses; included by its bare name.
//
// How it works
// - Released one read low: collision, go idle
// - Byte collision: halt, clear full, release lines
// - Sequence collision: abort, release, clear enable bit
// - After collision, stop on bus sets event
// - Buffer write starts at first data bit
// - Start and stop detection raise events
// - Line low at start begin: collision
// - Start counts with data high; clock low collides
// - Data low in first count: drive early
// - Second start count ignores clock, then clock low
// - Repeated start: data low at clock high collides
// - Data fall fine; clock fall undriven collides
// - Both high at timeout: data low, recount
// - Stop: data low after timeout collides
// - Stop: clock low before data release collides
// - Counter waits for clock high, then reloads
`ifndef I2C_COLL_DEFS_SVH
`define I2C_COLL_DEFS_SVH
// ==========================================
// Register byte offsets
`define OFS_SEQ_CTRL 8'h00
`define OFS_RATE 8'h04
`define OFS_XFER_BUF 8'h08
`define OFS_PORT_STAT 8'h0C
`define OFS_IRQ_STAT 8'h10
`define OFS_IRQ_MASK 8'h14
// ==========================================
// Sequence control fields
`define SEQ_START 0
`define SEQ_RSTART 1
`define SEQ_STOP 2
`define SEQ_ACK 3
`define SEQ_ACK_DATA 4
// Port status fields
`define PST_FULL 0
`define PST_START_SEEN 1
`define PST_STOP_SEEN 2
`define PST_ACK_STATUS 3
`define PST_BUSY 4
// Interrupt status and mask fields
`define IRQ_COLL 0
`define IRQ_EVENT 1
`define IRQ_START 2
`define IRQ_STOP 3
// ==========================================
// Reset values
`define RATE_RESET 7'h10
`define MASK_RESET 4'h0
`endif

// [core/i2c_coll_pkg.sv]
// Types shared by the collision-aware two-wire master port.
// Assumes the defs header supplies all numeric constants.
package i2c_coll_pkg;
  // ==========================================
  // Sequencer states, one-hot
  typedef enum logic [14:0] {
    S_IDLE    = 15'h0001,
    S_ST_CHK  = 15'h0002,
    S_ST_CNT1 = 15'h0004,
    S_ST_CNT2 = 15'h0008,
    S_RS_CNT1 = 15'h0010,
    S_RS_WAIT = 15'h0020,
    S_RS_CNT2 = 15'h0040,
    S_RS_CNT3 = 15'h0080,
    S_SP_LOW  = 15'h0100,
    S_SP_WAIT = 15'h0200,
    S_SP_CNT1 = 15'h0400,
    S_SP_CNT2 = 15'h0800,
    S_BIT_LOW = 15'h1000,
    S_BIT_WAIT = 15'h2000,
    S_BIT_HIGH = 15'h4000
  } seq_state_t;
  // Filtered levels of both bus lines
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_t;
endpackage

// [core/i2c_master_bus_collision.sv]
// Two-wire master port with arbitration and bus collision handling, APB registers.
// Assumes open-drain pads outside: OE high pulls the line low; lines come in asynchronous.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_coll_defs.svh"
module i2c_master_bus_collision
(
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE_OUT,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  output logic IRQ_OUT,
  output i2c_coll_pkg::bus_lines_t LINES_OUT
);
  import i2c_coll_pkg::*;

  // ==========================================
  // Declarations
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] sync3;
  bus_lines_t lvl;
  bus_lines_t lvl_prev;
  seq_state_t state;
  logic [6:0] rate_reload_value;
  logic [6:0] rate_counter;
  logic [4:0] sequence_control_register;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic buffer_full_flag;
  logic [7:0] transfer_buffer;
  logic [8:0] shifter;
  logic [3:0] bits_left;
  logic arb_all;
  logic ack_status;
  logic start_seen;
  logic stop_seen;
  logic after_coll;
  logic scl_drv;
  logic sda_drv;
  logic rate_zero;
  logic coll;
  logic arb_check;
  logic start_det;
  logic stop_det;
  logic [4:0] seq_clr;
  logic done_any;
  logic apb_wr;
  logic apb_rd;
  logic mapped;
  logic idle;
  logic buf_go;
  logic [31:0] next_rdata;
  logic [3:0] next_irq_set;

  // ==========================================
  // Line synchronisers
  // Three stages; a level counts only once stages two and three agree
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      sync1 <= 2'h3;
      sync2 <= 2'h3;
      sync3 <= 2'h3;
    end
    else
    begin
      sync1 <= {SCL_IN, SDA_IN};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Filtered levels and the previous sample for condition detection
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      lvl <= '{scl: 1'b1, sda: 1'b1};
      lvl_prev <= '{scl: 1'b1, sda: 1'b1};
    end
    else
    begin
      if (sync2 == sync3)
      begin
        lvl <= sync3;
      end
      lvl_prev <= lvl;
    end
  end

  // Start and stop seen on the bus, whoever made them
  assign start_det = lvl.scl && lvl_prev.scl && lvl_prev.sda && !lvl.sda;
  assign stop_det = lvl.scl && lvl_prev.scl && !lvl_prev.sda && lvl.sda;

  // ==========================================
  // Bus access decode
  assign apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign apb_rd = PSEL_IN && PENABLE_IN && !PWRITE_IN;
  assign idle = (state == S_IDLE);
  // Buffer writes only taken while idle with no sequence pending
  assign buf_go = apb_wr && PADDR_IN == `OFS_XFER_BUF && idle
    && sequence_control_register[3:0] == 4'h0;

  always_comb
  begin
    mapped = 1'b1;
    next_rdata = 32'h0000_0000;
    case (PADDR_IN)
      `OFS_SEQ_CTRL: next_rdata = {27'h0, sequence_control_register};
      `OFS_RATE: next_rdata = {25'h0, rate_reload_value};
      `OFS_XFER_BUF: next_rdata = {24'h0, transfer_buffer};
      `OFS_PORT_STAT: next_rdata = {27'h0, !idle, ack_status, stop_seen, start_seen,
        buffer_full_flag};
      `OFS_IRQ_STAT: next_rdata = {28'h0, irq_stat};
      `OFS_IRQ_MASK: next_rdata = {28'h0, irq_mask};
      default: mapped = 1'b0;
    endcase
  end

  // Zero wait states; unmapped addresses answer with an error
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;

  // Read data latched in the setup cycle so it comes from a flop
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      PRDATA_OUT <= 32'h0000_0000;
    end
    else if (PSEL_IN && !PENABLE_IN)
    begin
      PRDATA_OUT <= next_rdata;
    end
  end

  // Writable configuration
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      rate_reload_value <= `RATE_RESET;
      irq_mask <= `MASK_RESET;
      transfer_buffer <= 8'h00;
    end
    else
    begin
      if (apb_wr && PADDR_IN == `OFS_RATE)
      begin
        rate_reload_value <= PWDATA_IN[6:0];
      end
      if (apb_wr && PADDR_IN == `OFS_IRQ_MASK)
      begin
        irq_mask <= PWDATA_IN[3:0];
      end
      if (buf_go)
      begin
        transfer_buffer <= PWDATA_IN[7:0];
      end
    end
  end

  // ==========================================
  // Collision detection per sequencer state
  assign rate_zero = (rate_counter == 7'h00);
  assign arb_check = arb_all || bits_left != 4'h0;

  always_comb
  begin
    coll = 1'b0;
    case (state)
      S_ST_CHK: coll = !lvl.sda || !lvl.scl;
      S_ST_CNT1: coll = lvl.sda && !lvl.scl;
      S_RS_WAIT: coll = lvl.scl && !lvl.sda;
      S_RS_CNT2: coll = !lvl.scl && lvl.sda;
      S_SP_CNT1: coll = !lvl.scl;
      S_SP_CNT2: coll = rate_zero && !lvl.sda;
      // Only a released one can lose; the acknowledge slot belongs to the slave
      S_BIT_HIGH: coll = arb_check && shifter[8] && !lvl.sda;
      default: coll = 1'b0;
    endcase
  end

  // Sequence completions clear their enable bit and raise the event
  always_comb
  begin
    seq_clr = 5'h00;
    done_any = 1'b0;
    if (coll)
    begin
      seq_clr = 5'h0F;
    end
    else if (rate_zero)
    begin
      case (state)
        S_ST_CNT2: seq_clr[`SEQ_START] = 1'b1;
        S_RS_CNT3: seq_clr[`SEQ_RSTART] = 1'b1;
        S_SP_CNT2: seq_clr[`SEQ_STOP] = 1'b1;
        S_BIT_HIGH: seq_clr[`SEQ_ACK] = arb_all && bits_left == 4'h0;
        default: seq_clr = 5'h00;
      endcase
      done_any = (state == S_ST_CNT2) || (state == S_RS_CNT3) || (state == S_SP_CNT2)
        || (state == S_BIT_HIGH && bits_left == 4'h0);
    end
  end

  // Sequence enables: taken only while idle, cleared by hardware
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      sequence_control_register <= 5'h00;
    end
    else if (apb_wr && PADDR_IN == `OFS_SEQ_CTRL && idle)
    begin
      sequence_control_register <= PWDATA_IN[4:0];
    end
    else
    begin
      sequence_control_register <= sequence_control_register & ~seq_clr;
    end
  end

  // Buffer full: set by an accepted write, cleared at byte end or collision
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      buffer_full_flag <= 1'b0;
    end
    else if (buf_go)
    begin
      buffer_full_flag <= 1'b1;
    end
    else if (coll || (state == S_BIT_HIGH && rate_zero && bits_left == 4'h0 && !arb_all))
    begin
      buffer_full_flag <= 1'b0;
    end
  end

  // ==========================================
  // Sequencer with rate counter
  // Counter is owned here so load and count never race
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      state <= S_IDLE;
      rate_counter <= 7'h00;
      scl_drv <= 1'b0;
      sda_drv <= 1'b0;
      shifter <= 9'h000;
      bits_left <= 4'h0;
      arb_all <= 1'b0;
      ack_status <= 1'b0;
    end
    else if (coll)
    begin
      state <= S_IDLE;
      scl_drv <= 1'b0;
      sda_drv <= 1'b0;
    end
    else
    begin
      if (!rate_zero)
      begin
        rate_counter <= rate_counter - 7'h01;
      end
      case (state)
        S_IDLE:
        begin
          if (sequence_control_register[`SEQ_START])
          begin
            scl_drv <= 1'b0;
            sda_drv <= 1'b0;
            state <= S_ST_CHK;
          end
          else if (sequence_control_register[`SEQ_RSTART])
          begin
            sda_drv <= 1'b0;
            rate_counter <= rate_reload_value;
            state <= S_RS_CNT1;
          end
          else if (sequence_control_register[`SEQ_STOP])
          begin
            sda_drv <= 1'b1;
            state <= S_SP_LOW;
          end
          else if (sequence_control_register[`SEQ_ACK])
          begin
            shifter <= {sequence_control_register[`SEQ_ACK_DATA], 8'hFF};
            sda_drv <= !sequence_control_register[`SEQ_ACK_DATA];
            scl_drv <= 1'b1;
            bits_left <= 4'h0;
            arb_all <= 1'b1;
            rate_counter <= rate_reload_value;
            state <= S_BIT_LOW;
          end
          else if (buf_go)
          begin
            // Always restart from the first data bit, plus a released acknowledge slot
            shifter <= {PWDATA_IN[7:0], 1'b1};
            sda_drv <= !PWDATA_IN[7];
            scl_drv <= 1'b1;
            bits_left <= 4'h8;
            arb_all <= 1'b0;
            rate_counter <= rate_reload_value;
            state <= S_BIT_LOW;
          end
        end
        S_ST_CHK:
        begin
          rate_counter <= rate_reload_value;
          state <= S_ST_CNT1;
        end
        S_ST_CNT1:
        begin
          // Another master's start: follow it at once, not a collision
          if (!lvl.sda || rate_zero)
          begin
            sda_drv <= 1'b1;
            rate_counter <= rate_reload_value;
            state <= S_ST_CNT2;
          end
        end
        S_ST_CNT2:
        begin
          if (rate_zero)
          begin
            scl_drv <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_RS_CNT1:
        begin
          if (rate_zero)
          begin
            scl_drv <= 1'b0;
            state <= S_RS_WAIT;
          end
        end
        S_RS_WAIT:
        begin
          // Counter suspended until the clock really rises
          if (lvl.scl)
          begin
            rate_counter <= rate_reload_value;
            state <= S_RS_CNT2;
          end
        end
        S_RS_CNT2:
        begin
          if (rate_zero)
          begin
            sda_drv <= 1'b1;
            rate_counter <= rate_reload_value;
            state <= S_RS_CNT3;
          end
        end
        S_RS_CNT3:
        begin
          if (rate_zero)
          begin
            scl_drv <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_SP_LOW:
        begin
          if (!lvl.sda)
          begin
            scl_drv <= 1'b0;
            state <= S_SP_WAIT;
          end
        end
        S_SP_WAIT:
        begin
          if (lvl.scl)
          begin
            rate_counter <= rate_reload_value;
            state <= S_SP_CNT1;
          end
        end
        S_SP_CNT1:
        begin
          if (rate_zero)
          begin
            sda_drv <= 1'b0;
            rate_counter <= rate_reload_value;
            state <= S_SP_CNT2;
          end
        end
        S_SP_CNT2:
        begin
          if (rate_zero)
          begin
            state <= S_IDLE;
          end
        end
        S_BIT_LOW:
        begin
          if (rate_zero)
          begin
            scl_drv <= 1'b0;
            state <= S_BIT_WAIT;
          end
        end
        S_BIT_WAIT:
        begin
          // A slave may stretch the clock; the high time starts when seen high
          if (lvl.scl)
          begin
            rate_counter <= rate_reload_value;
            state <= S_BIT_HIGH;
          end
        end
        S_BIT_HIGH:
        begin
          if (rate_zero)
          begin
            scl_drv <= 1'b1;
            if (bits_left == 4'h0)
            begin
              if (!arb_all)
              begin
                ack_status <= lvl.sda;
              end
              sda_drv <= 1'b0;
              state <= S_IDLE;
            end
            else
            begin
              shifter <= {shifter[7:0], 1'b1};
              sda_drv <= !shifter[7];
              bits_left <= bits_left - 4'h1;
              rate_counter <= rate_reload_value;
              state <= S_BIT_LOW;
            end
          end
        end
        default:
        begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Bus state watch
  // Bus busy from a start until a stop; after a collision wait for the stop
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
      after_coll <= 1'b0;
    end
    else
    begin
      if (start_det)
      begin
        start_seen <= 1'b1;
        stop_seen <= 1'b0;
      end
      else if (stop_det)
      begin
        start_seen <= 1'b0;
        stop_seen <= 1'b1;
      end
      if (coll)
      begin
        after_coll <= 1'b1;
      end
      else if (stop_det)
      begin
        after_coll <= 1'b0;
      end
    end
  end

  // ==========================================
  // Interrupt status: read clears, a new event in the same cycle wins
  always_comb
  begin
    next_irq_set = 4'h0;
    next_irq_set[`IRQ_COLL] = coll;
    next_irq_set[`IRQ_EVENT] = done_any || (after_coll && stop_det);
    next_irq_set[`IRQ_START] = start_det;
    next_irq_set[`IRQ_STOP] = stop_det;
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      irq_stat <= 4'h0;
    end
    else if (apb_rd && PADDR_IN == `OFS_IRQ_STAT)
    begin
      // Clear only what the read reported; a bit set since the setup cycle survives
      irq_stat <= (irq_stat & ~PRDATA_OUT[3:0]) | next_irq_set;
    end
    else
    begin
      irq_stat <= irq_stat | next_irq_set;
    end
  end

  assign IRQ_OUT = |(irq_stat & irq_mask);

  // Open-drain pads: output level fixed low, enable pulls the line
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SCL_OE_OUT = scl_drv;
  assign SDA_OE_OUT = sda_drv;
  assign LINES_OUT = lvl;

  // ==========================================
  // Checks
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  a_bit_arb_loss: assert property (
    (state == S_BIT_HIGH && arb_check && shifter[8] && !lvl.sda)
    |=> (state == S_IDLE && irq_stat[`IRQ_COLL]))
    else $error("released one read low did not abort");
  a_coll_release: assert property (
    coll |=> (!scl_drv && !sda_drv && !buffer_full_flag && state == S_IDLE))
    else $error("lines or full flag not released after collision");
  a_coll_seq_clear: assert property (
    coll |=> sequence_control_register[3:0] == 4'h0)
    else $error("sequence enable left set after collision");
  a_stop_event: assert property (
    (after_coll && stop_det) |=> irq_stat[`IRQ_EVENT])
    else $error("stop after collision gave no event");
  a_first_bit: assert property (
    buf_go |=> (state == S_BIT_LOW && sda_drv == !$past(PWDATA_IN[7]) && bits_left == 4'h8))
    else $error("transfer did not start at first data bit");
  a_cond_events: assert property (
    (start_det || stop_det) |=> ((irq_stat[`IRQ_START] || !$past(start_det))
    && (irq_stat[`IRQ_STOP] || !$past(stop_det))))
    else $error("start or stop detection raised no event");
  a_start_busy: assert property (
    (state == S_ST_CHK && !(lvl.sda && lvl.scl)) |=> (state == S_IDLE && irq_stat[`IRQ_COLL]))
    else $error("start over busy bus not aborted");
  a_start_clk_low: assert property (
    (state == S_ST_CNT1 && lvl.sda && !lvl.scl) |=> irq_stat[`IRQ_COLL])
    else $error("clock low during start count not flagged");
  a_start_early: assert property (
    (state == S_ST_CNT1 && !lvl.sda) |=> (state == S_ST_CNT2 && sda_drv
    && !$rose(irq_stat[`IRQ_COLL]) && rate_counter == rate_reload_value))
    else $error("early data low not followed");
  a_start_finish: assert property (
    (state == S_ST_CNT2 && rate_zero) |=> (scl_drv && sda_drv && state == S_IDLE))
    else $error("start did not end with clock low");
  a_rs_data_low: assert property (
    (state == S_RS_WAIT && lvl.scl && !lvl.sda) |=> irq_stat[`IRQ_COLL])
    else $error("repeated start data low not flagged");
  a_rs_clk_fall: assert property (
    (state == S_RS_CNT2 && !lvl.scl && lvl.sda) |=> (state == S_IDLE && irq_stat[`IRQ_COLL]))
    else $error("clock fall in repeated start not flagged");
  a_rs_finish: assert property (
    (state == S_RS_CNT2 && rate_zero && lvl.scl && lvl.sda) |=> (state == S_RS_CNT3 && sda_drv))
    else $error("repeated start did not drive data low");
  a_stop_data_low: assert property (
    (state == S_SP_CNT2 && rate_zero && !lvl.sda) |=> irq_stat[`IRQ_COLL])
    else $error("stop data low after timeout not flagged");
  a_stop_clk_low: assert property (
    (state == S_SP_CNT1 && !lvl.scl) |=> (state == S_IDLE && !sda_drv && irq_stat[`IRQ_COLL]))
    else $error("clock low in stop not flagged");
  a_clock_wait: assert property (
    (state == S_BIT_WAIT && !lvl.scl) |=> (state == S_BIT_WAIT && $stable(rate_counter)))
    else $error("counter ran while clock held low");
  a_coll_sticky: assert property (
    (irq_stat[`IRQ_COLL] && !(apb_rd && PADDR_IN == `OFS_IRQ_STAT)) |=> irq_stat[`IRQ_COLL])
    else $error("collision flag dropped without a read");

  c_byte_done: cover property (state == S_BIT_HIGH && rate_zero && bits_left == 4'h0);
  c_start_coll: cover property (state == S_ST_CNT1 && coll);
  c_rs_done: cover property (state == S_RS_CNT3 && rate_zero);
  c_stop_coll: cover property (state == S_SP_CNT2 && coll);
endmodule
`default_nettype wire

// [testbench/bus_far_party.sv]
// Far side of the two-wire bus: pull-ups plus another party that may pull a line low.
// Assumes the bench drives the hold controls by non-blocking assignment after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module bus_far_party
(
  input wire logic dut_scl_oe_in,
  input wire logic dut_sda_oe_in,
  input wire logic hold_scl_in,
  input wire logic hold_sda_in,
  output logic scl_out,
  output logic sda_out
);
  // ==========================================
  // Wired-AND with pull-up: a released line reads high, never stale
  assign scl_out = !(dut_scl_oe_in || hold_scl_in);
  assign sda_out = !(dut_sda_oe_in || hold_sda_in);
endmodule
`default_nettype wire

// [testbench/tb_i2c_master_bus_collision.sv]
// Self-checking bench: APB register tasks, collisions at start, in a byte, ack and stop.
// Assumes the port answers with zero wait states and the far party model above.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_coll_defs.svh"
module tb_i2c_master_bus_collision;
  import i2c_coll_pkg::*;
  logic clk, rst, psel, pen, pwr, pready, slverr, irq, err;
  logic scl_w, sda_w, scl_oe, sda_oe, hold_scl, hold_sda;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  bus_lines_t lines;
  int bad_count, n_checks;
  // ==========================================
  // Clock and instances
  initial
  begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end
  i2c_master_bus_collision dut_u (.MCLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(slverr), .SCL_IN(scl_w),
    .SCL_OUT(), .SCL_OE_OUT(scl_oe), .SDA_IN(sda_w), .SDA_OUT(), .SDA_OE_OUT(sda_oe),
    .IRQ_OUT(irq), .LINES_OUT(lines));
  bus_far_party far_u (.dut_scl_oe_in(scl_oe), .dut_sda_oe_in(sda_oe),
    .hold_scl_in(hold_scl), .hold_sda_in(hold_sda), .scl_out(scl_w), .sda_out(sda_w));
  // ==========================================
  // Checking and closing
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // APB transfer; entered just after a rising edge, holds until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        bad_count++;
        final_report();
      end
      @(posedge clk);
    end
    rd = prdata;
    err = slverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // Poll busy under a bound so a hung sequencer ends the run
  task automatic wait_idle();
    int n;
    n = 0;
    rd = 32'h0000_0010;
    while (rd[`PST_BUSY] !== 1'b0)
    begin
      n++;
      if (n > 300)
      begin
        bad_count++;
        final_report();
      end
      apb(1'b0, `OFS_PORT_STAT, 32'h0);
    end
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    bad_count = 0;
    n_checks = 0;
    rst = 1'b1;
    {psel, pen, pwr, hold_scl, hold_sda} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk("lines idle", lines, 32'h3);
    apb(1'b0, `OFS_RATE, 32'h0);
    chk("rate reset", rd, 32'h0000_0010);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped read", {rd[30:0], err}, 32'h0000_0001);
    // Other party holds data low: start must abort with collision
    apb(1'b1, `OFS_IRQ_MASK, 32'h0000_0001);
    hold_sda <= 1'b1;
    repeat (8) @(posedge clk);
    chk("lines follow bus", lines, 32'h2);
    apb(1'b1, `OFS_SEQ_CTRL, 32'h0000_0001);
    wait_idle();
    apb(1'b0, `OFS_SEQ_CTRL, 32'h0);
    chk("start bit cleared", rd, 32'h0);
    chk("lines released", {scl_oe, sda_oe, irq}, 32'h1);
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk("start det and collision", rd & 32'h5, 32'h5);
    chk("irq after clear", irq, 32'h0);
    hold_sda <= 1'b0;
    repeat (12) @(posedge clk);
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk("stop after collision", rd & 32'hA, 32'hA);
    // Clock held low by the other party: start must abort as well
    hold_scl <= 1'b1;
    repeat (8) @(posedge clk);
    apb(1'b1, `OFS_SEQ_CTRL, 32'h0000_0001);
    wait_idle();
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk("clock low start", rd[`IRQ_COLL], 32'h1);
    hold_scl <= 1'b0;
    repeat (12) @(posedge clk);
    // Normal start, then a byte of ones lost to a zero from the other party
    apb(1'b1, `OFS_RATE, 32'h0000_0004);
    apb(1'b1, `OFS_SEQ_CTRL, 32'h0000_0001);
    wait_idle();
    chk("start holds lines", {scl_oe, sda_oe}, 32'h3);
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    apb(1'b1, `OFS_XFER_BUF, 32'h0000_00FF);
    chk("first bit released", sda_oe, 32'h0);
    for (int n = 0; n < 500 && !(scl_w === 1'b1 && sda_oe === 1'b0); n++)
      @(posedge clk);
    hold_sda <= 1'b1;
    wait_idle();
    chk("byte lines released", {scl_oe, sda_oe}, 32'h0);
    apb(1'b0, `OFS_PORT_STAT, 32'h0);
    chk("buffer full cleared", rd[`PST_FULL], 32'h0);
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk("byte collision", rd[`IRQ_COLL], 32'h1);
    hold_sda <= 1'b0;
    repeat (12) @(posedge clk);
    // After the bus is free, a new start is accepted again
    apb(1'b1, `OFS_SEQ_CTRL, 32'h0000_0001);
    wait_idle();
    chk("restart holds lines", {scl_oe, sda_oe}, 32'h3);
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    // Repeated start, then an acknowledge of one lost to a held data line
    apb(1'b1, `OFS_SEQ_CTRL, 32'h0000_0002);
    wait_idle();
    chk("rstart holds lines", {scl_oe, sda_oe}, 32'h3);
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk("rstart start det", rd & 32'h6, 32'h6);
    hold_sda <= 1'b1;
    apb(1'b1, `OFS_SEQ_CTRL, 32'h0000_0018);
    wait_idle();
    apb(1'b0, `OFS_SEQ_CTRL, 32'h0);
    chk("ack enable cleared", rd, 32'h0000_0010);
    chk("ack lines released", {scl_oe, sda_oe}, 32'h0);
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk("ack collision", rd[`IRQ_COLL], 32'h1);
    hold_sda <= 1'b0;
    repeat (12) @(posedge clk);
    // Stop whose released data line stays low: collision after timeout
    apb(1'b1, `OFS_SEQ_CTRL, 32'h0000_0001);
    wait_idle();
    hold_sda <= 1'b1;
    apb(1'b1, `OFS_SEQ_CTRL, 32'h0000_0004);
    wait_idle();
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk("stop collision", rd[`IRQ_COLL], 32'h1);
    hold_sda <= 1'b0;
    repeat (12) @(posedge clk);
    // Clean start and stop
    apb(1'b1, `OFS_SEQ_CTRL, 32'h0000_0001);
    wait_idle();
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    apb(1'b1, `OFS_SEQ_CTRL, 32'h0000_0004);
    wait_idle();
    chk("stop releases lines", {scl_oe, sda_oe}, 32'h0);
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk("stop events", rd & 32'hA, 32'hA);
    apb(1'b0, `OFS_PORT_STAT, 32'h0);
    chk("stop seen", rd[`PST_STOP_SEEN], 32'h1);
    final_report();
  end
endmodule
`default_nettype wire
